//--- atc_map.vh
// register map and field constants for the adaptive threshold block
`ifndef ATC_MAP_VH
`define ATC_MAP_VH
`define ATC_CFG_INDEX 8'h0F
`define ATC_CFG_ADDR 8'h3C
`define ATC_SETUP_ADDR 8'h40
`define ATC_ISTAT_ADDR 8'h44
`define ATC_IMASK_ADDR 8'h48
`define ATC_STATE_ADDR 8'h4C
`define ATC_AVG1_ADDR 8'h50
`define ATC_AVG2_ADDR 8'h54
`define ATC_CFG_RESET 8'h19
`define ATC_SETUP_RESET 5'h00
`define ATC_IMASK_RESET 4'h0
`define ATC_CFG_FIXED 7
`define ATC_CFG_CMP_HI 6
`define ATC_CFG_CMP_LO 5
`define ATC_CFG_EN1 4
`define ATC_CFG_EN2 3
`define ATC_SETUP_HYST_DIS 4
`define ATC_CMP_NEG 2'h0
`define ATC_CMP_POS 2'h1
`define ATC_CMP_IN 2'h2
`define ATC_CMP_OUT 2'h3
`define ATC_MODE_IDLE 3'h0
`define ATC_MODE_CONT 3'h1
`define ATC_MODE_SINGLE 3'h2
`define ATC_MODE_PDOWN 3'h3
`define ATC_IRQ_DET1 0
`define ATC_IRQ_DET2 1
`define ATC_IRQ_CONV 2
`define ATC_IRQ_SEQ 3
`endif

//--- atc_chan.v
// one channel: running average and threshold comparator
`include "atc_map.vh"
`default_nettype none
module atc_chan #(
   parameter DW = 16,
   parameter FW = 16
) (
   input wire pclk,
   input wire presetn,
   input wire sample,
   input wire [DW-1:0] data,
   input wire [3:0] settle,
   input wire fixed_sel,
   input wire [1:0] cmp_mode,
   input wire hyst_dis,
   input wire [DW-1:0] sens,
   input wire [DW-1:0] thr,
   input wire [DW-1:0] hyst,
   output reg det_r,
   output wire [DW-1:0] avg_int
);
   reg [DW+FW-1:0] avg_r;
   reg seeded_r;
   wire signed [DW+FW:0] diff;
   wire signed [DW+FW:0] step;
   wire [4:0] shamt;
   wire signed [DW+1:0] d, a, s, t, h, lo, hi;
   reg det_nxt;

   assign avg_int = avg_r[DW+FW-1:FW];
   assign shamt = {1'b0, settle} + 5'h01;
   assign diff = $signed({1'b0, data, {FW{1'b0}}}) - $signed({1'b0, avg_r});
   assign step = diff >>> shamt;
   assign d = $signed({2'b00, data});
   assign a = $signed({2'b00, avg_int});
   assign s = $signed({2'b00, sens});
   assign t = $signed({2'b00, thr});
   // hysteresis only in adaptive mode and only while active
   assign h = (!fixed_sel && !hyst_dis && det_r) ? $signed({2'b00, hyst}) :
      $signed({(DW+2){1'b0}});
   assign lo = a - s;
   assign hi = a + s;

   always @* begin
      det_nxt = 1'b0;
      if (fixed_sel) begin
         if (cmp_mode[0] == 1'b0) begin
            det_nxt = (d < t);
         end else begin
            det_nxt = (d > t);
         end
      end else begin
         case (cmp_mode)
            `ATC_CMP_NEG: det_nxt = (d < lo + h);
            `ATC_CMP_POS: det_nxt = (d > hi - h);
            `ATC_CMP_IN: det_nxt = (d > lo - h) && (d < hi + h);
            `ATC_CMP_OUT: det_nxt = (d < lo + h) || (d > hi - h);
            default: det_nxt = 1'b0;
         endcase
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         avg_r <= {(DW+FW){1'b0}};
         seeded_r <= 1'b0;
         det_r <= 1'b0;
      end else if (sample) begin
         seeded_r <= 1'b1;
         if (!seeded_r) begin
            avg_r <= {data, {FW{1'b0}}};
         end else begin
            avg_r <= avg_r + step[DW+FW-1:0];
         end
         det_r <= seeded_r ? det_nxt : 1'b0;
      end
   end
endmodule // atc_chan
`default_nettype wire

//--- atc_top.v
// adaptive threshold configuration, sequencing and apb registers
//
// Notes on behaviour
// - hysteresis-disable bit drops adaptive hysteresis only
// - average steps by difference shifted settling+1
// - time constant two to settling plus one
// - average advances once per finished conversion
// - config register 8-bit, index 0x0F, reset 0x19
// - fixed select compares against threshold values
// - cleared fixed select uses adaptive average thresholds
// - mode zero: below lower limit asserts
// - modes one to three: above, inside, outside; fixed select uses bit 0 only, so two is below, three above
// - conversion mode idle, continuous, single, powerdown
`include "atc_map.vh"
`default_nettype none
module atc_top #(
   parameter DW = 16,
   parameter FW = 16
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   output reg conv_start,
   output reg conv_channel,
   input wire conv_done,
   input wire [DW-1:0] conv_data,
   output wire power_down,
   input wire [DW-1:0] sens_ch1,
   input wire [DW-1:0] sens_ch2,
   input wire [DW-1:0] thr_ch1,
   input wire [DW-1:0] thr_ch2,
   input wire [DW-1:0] hyst_ch1,
   input wire [DW-1:0] hyst_ch2,
   output wire [1:0] detect,
   output wire irq
);
   localparam S_IDLE = 1'b0;
   localparam S_WAIT = 1'b1;

   reg [7:0] cfg_r;
   reg [4:0] setup_r;
   reg [3:0] istat_r;
   reg [3:0] imask_r;
   reg state_r;
   reg [1:0] done_r;
   reg last_r;
   reg [1:0] det_d_r;
   reg [3:0] ev;
   reg [7:0] cfg_nxt;
   reg [1:0] done_nxt;
   reg state_nxt;
   reg start_nxt;
   reg chan_nxt;
   reg seq_end;
   reg conv_ev;
   reg [1:0] avail;
   reg [31:0] rd_nxt;
   reg addr_ok;

   wire setup_ph;
   wire access_ph;
   wire wr_acc;
   wire [2:0] mode;
   wire [1:0] en;
   wire [1:0] sample;
   wire [DW-1:0] avg1;
   wire [DW-1:0] avg2;

   assign setup_ph = psel && !penable;
   assign access_ph = psel && penable;
   assign pready = 1'b1;
   assign pslverr = access_ph && !addr_ok;
   assign wr_acc = access_ph && pwrite && addr_ok;
   assign mode = cfg_r[2:0];
   assign en = {cfg_r[`ATC_CFG_EN2], cfg_r[`ATC_CFG_EN1]};
   assign power_down = (mode == `ATC_MODE_PDOWN);
   assign irq = |(istat_r & imask_r);
   assign sample[0] = (state_r == S_WAIT) && conv_done && (conv_channel == 1'b0);
   assign sample[1] = (state_r == S_WAIT) && conv_done && (conv_channel == 1'b1);

   // address decode
   always @* begin
      case (paddr)
         `ATC_CFG_ADDR: addr_ok = 1'b1;
         `ATC_SETUP_ADDR: addr_ok = 1'b1;
         `ATC_ISTAT_ADDR: addr_ok = 1'b1;
         `ATC_IMASK_ADDR: addr_ok = 1'b1;
         `ATC_STATE_ADDR: addr_ok = 1'b1;
         `ATC_AVG1_ADDR: addr_ok = 1'b1;
         `ATC_AVG2_ADDR: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // read data, latched in the setup cycle
   always @* begin
      rd_nxt = 32'h00000000;
      case (paddr)
         `ATC_CFG_ADDR: rd_nxt[7:0] = cfg_r;
         `ATC_SETUP_ADDR: rd_nxt[4:0] = setup_r;
         `ATC_ISTAT_ADDR: rd_nxt[3:0] = istat_r;
         `ATC_IMASK_ADDR: rd_nxt[3:0] = imask_r;
         `ATC_STATE_ADDR: rd_nxt[5:0] = {state_r, conv_channel, done_r, detect};
         `ATC_AVG1_ADDR: rd_nxt[DW-1:0] = avg1;
         `ATC_AVG2_ADDR: rd_nxt[DW-1:0] = avg2;
         default: rd_nxt = 32'h00000000;
      endcase
   end

   // conversion sequencer
   always @* begin
      state_nxt = state_r;
      done_nxt = done_r;
      start_nxt = 1'b0;
      chan_nxt = conv_channel;
      seq_end = 1'b0;
      conv_ev = 1'b0;
      cfg_nxt = cfg_r;
      avail = en & ~done_r;
      case (state_r)
         S_IDLE: begin
            if (mode == `ATC_MODE_CONT && en != 2'b00) begin
               if (avail == 2'b00) begin
                  avail = en;
                  done_nxt = 2'b00;
               end
               start_nxt = 1'b1;
               state_nxt = S_WAIT;
            end else if (mode == `ATC_MODE_SINGLE) begin
               if (avail == 2'b00) begin
                  seq_end = 1'b1;
                  done_nxt = 2'b00;
                  cfg_nxt = {cfg_r[7:3], `ATC_MODE_IDLE};
               end else begin
                  start_nxt = 1'b1;
                  state_nxt = S_WAIT;
               end
            end else begin
               done_nxt = 2'b00;
            end
            if (start_nxt) begin
               if (avail == 2'b11) begin
                  chan_nxt = ~last_r;
               end else begin
                  chan_nxt = avail[1];
               end
            end
         end
         S_WAIT: begin
            // a started conversion always runs to completion
            if (conv_done) begin
               conv_ev = 1'b1;
               state_nxt = S_IDLE;
               if (conv_channel) begin
                  done_nxt = done_r | 2'b10;
               end else begin
                  done_nxt = done_r | 2'b01;
               end
            end
         end
         default: state_nxt = S_IDLE;
      endcase
   end

   always @* begin
      ev = 4'h0;
      ev[`ATC_IRQ_DET1] = detect[0] && !det_d_r[0];
      ev[`ATC_IRQ_DET2] = detect[1] && !det_d_r[1];
      ev[`ATC_IRQ_CONV] = conv_ev;
      ev[`ATC_IRQ_SEQ] = seq_end;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r <= `ATC_CFG_RESET;
         setup_r <= `ATC_SETUP_RESET;
         istat_r <= 4'h0;
         imask_r <= `ATC_IMASK_RESET;
         state_r <= S_IDLE;
         done_r <= 2'b00;
         last_r <= 1'b1;
         det_d_r <= 2'b00;
         conv_start <= 1'b0;
         conv_channel <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         state_r <= state_nxt;
         done_r <= done_nxt;
         conv_start <= start_nxt;
         conv_channel <= chan_nxt;
         det_d_r <= detect;
         if (start_nxt) begin
            last_r <= chan_nxt;
         end
         if (setup_ph) begin
            prdata <= rd_nxt;
         end
         // software write to config wins over the end-of-sequence idle
         if (wr_acc && paddr == `ATC_CFG_ADDR) begin
            cfg_r <= pwdata[7:0];
         end else begin
            cfg_r <= cfg_nxt;
         end
         if (wr_acc && paddr == `ATC_SETUP_ADDR) begin
            setup_r <= pwdata[4:0];
         end
         if (wr_acc && paddr == `ATC_IMASK_ADDR) begin
            imask_r <= pwdata[3:0];
         end
         // new events win over a same-cycle clear
         if (wr_acc && paddr == `ATC_ISTAT_ADDR) begin
            istat_r <= (istat_r & ~pwdata[3:0]) | ev;
         end else begin
            istat_r <= istat_r | ev;
         end
      end
   end

   atc_chan #(
      .DW(DW),
      .FW(FW)
   ) u_ch1 (
      .pclk(pclk),
      .presetn(presetn),
      .sample(sample[0]),
      .data(conv_data),
      .settle(setup_r[3:0]),
      .fixed_sel(cfg_r[`ATC_CFG_FIXED]),
      .cmp_mode(cfg_r[`ATC_CFG_CMP_HI:`ATC_CFG_CMP_LO]),
      .hyst_dis(setup_r[`ATC_SETUP_HYST_DIS]),
      .sens(sens_ch1),
      .thr(thr_ch1),
      .hyst(hyst_ch1),
      .det_r(detect[0]),
      .avg_int(avg1)
   );

   atc_chan #(
      .DW(DW),
      .FW(FW)
   ) u_ch2 (
      .pclk(pclk),
      .presetn(presetn),
      .sample(sample[1]),
      .data(conv_data),
      .settle(setup_r[3:0]),
      .fixed_sel(cfg_r[`ATC_CFG_FIXED]),
      .cmp_mode(cfg_r[`ATC_CFG_CMP_HI:`ATC_CFG_CMP_LO]),
      .hyst_dis(setup_r[`ATC_SETUP_HYST_DIS]),
      .sens(sens_ch2),
      .thr(thr_ch2),
      .hyst(hyst_ch2),
      .det_r(detect[1]),
      .avg_int(avg2)
   );
endmodule // atc_top
`default_nettype wire

//--- atc_top_properties.sv
// port-level assertion checker for the adaptive threshold block
`default_nettype none
module atc_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic conv_start,
   input wire logic conv_channel,
   input wire logic conv_done,
   input wire logic power_down,
   input wire logic [1:0] detect,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_rdy; pready; endproperty
   a_rdy: assert property (p_rdy) else $error("pready low");
   property p_err; pslverr |-> psel && penable; endproperty
   a_err: assert property (p_err) else $error("error outside access");
   property p_cfg; psel && penable && paddr == 8'h3C |-> !pslverr; endproperty
   a_cfg: assert property (p_cfg) else $error("config refused");
   property p_hole; psel && penable && paddr == 8'h60 |-> pslverr; endproperty
   a_hole: assert property (p_hole) else $error("hole accepted");
   property p_pulse; conv_start |=> !conv_start; endproperty
   a_pulse: assert property (p_pulse) else $error("start too long");
   property p_pd; power_down |-> !conv_start; endproperty
   a_pd: assert property (p_pd) else $error("start while down");
   property p_chan; !$stable(conv_channel) |-> conv_start; endproperty
   a_chan: assert property (p_chan) else $error("channel moved alone");
   property p_det; !$stable(detect) |-> $past(conv_done); endproperty
   a_det: assert property (p_det) else $error("detect without result");
   property p_pdw;
      $rose(power_down) |-> $past(psel && penable && pwrite && paddr == 8'h3C);
   endproperty
   a_pdw: assert property (p_pdw) else $error("power down unasked");
   c_conv: cover property (conv_done);
   c_err: cover property (pslverr);
   c_irq: cover property ($rose(irq));
endmodule // atc_chk
`default_nettype wire

//--- atc_top_tb.sv
// self-checking bench for the adaptive threshold block
`default_nettype none
module atc_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, conv_done = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, conv_start, conv_channel, power_down, irq, err;
   logic [15:0] conv_data = 16'h0, thr2 = 16'h0000;
   logic [1:0] detect;
   // power down flag beside config value
   logic [8:0] rows [4] = '{9'h058, 9'h1E3, 9'h03A, 9'h019};
   int failures = 0, samples_checked = 0;
   always #25 pclk = ~pclk;
   atc_top i_atc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .conv_start, .conv_channel, .conv_done, .conv_data,
      .power_down, .sens_ch1(16'h0064), .sens_ch2(16'h0064), .thr_ch1(16'h0190),
      .thr_ch2(thr2), .hyst_ch1(16'h0096), .hyst_ch2(16'h0096), .detect, .irq);
   task chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         failures++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, s, e);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (!pready) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task rchk(input logic [7:0] a, input logic [31:0] e);
      apb(0, a, 32'h0);
      chk(rd, e);
   endtask
   // answer the running conversion, then wait for the next start
   task conv(input logic ch, input logic [15:0] d);
      chk(conv_channel, ch);
      @(posedge pclk);
      conv_done <= 1;
      conv_data <= d;
      @(posedge pclk);
      conv_done <= 0;
      for (int n = 0; n < 20 && conv_start !== 1; n++) @(negedge pclk);
      chk(conv_start, 1);
   endtask
   task test_done;
      $display("checked %0d, failed %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge pclk);
      failures++;
      $display("unexpected at %0t: watchdog", $time);
      test_done;
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1;
      thr2 <= 16'h0190;
      rchk(8'h3C, 32'h19);
      rchk(8'h40, 32'h0);
      rchk(8'h48, 32'h0);
      $display("reset values done");
      apb(1, 8'h40, 32'h1);
      conv(0, 16'd1000);
      conv(1, 16'd500);
      conv(0, 16'd600);
      @(negedge pclk);
      chk(detect, 2'b01);
      rchk(8'h50, 32'd900);
      chk(irq, 0);
      apb(1, 8'h48, 32'h1);
      @(negedge pclk);
      chk(irq, 1);
      apb(1, 8'h44, 32'h1);
      @(negedge pclk);
      chk(irq, 0);
      $display("adaptive done");
      apb(1, 8'h3C, 32'hB9);
      conv(1, 16'd500);
      conv(0, 16'd300);
      @(negedge pclk);
      chk(detect, 2'b10);
      $display("fixed done");
      apb(1, 8'h3C, 32'h19);
      conv(1, 16'd500);
      @(negedge pclk);
      chk(detect, 2'b10);
      apb(1, 8'h40, 32'h11);
      conv(0, 16'd750);
      conv(1, 16'd500);
      @(negedge pclk);
      chk(detect, 2'b00);
      rchk(8'h54, 32'd500);
      rchk(8'h50, 32'd750);
      $display("hysteresis done");
      foreach (rows[i]) begin
         apb(1, 8'h3C, {24'h0, rows[i][7:0]});
         rchk(8'h3C, {24'h0, rows[i][7:0]});
         chk(power_down, rows[i][8]);
      end
      $display("rows done");
      apb(1, 8'h60, 32'hFF);
      chk(err, 1);
      rchk(8'h3C, 32'h19);
      $display("unmapped done");
      test_done;
   end
endmodule // atc_top_tb
bind atc_top atc_chk i_atc_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pready, .pslverr, .conv_start, .conv_channel, .conv_done, .power_down, .detect, .irq);
`default_nettype wire
